/* hdl/dma_pkg.sv */
// package: shared constants and carrier types of the four-channel transfer engine
package dma_pkg;

  // ==========================================================================
  // sizes and counts
  localparam int          NUM_CH       = 4;
  localparam int          NUM_SRC      = 5;
  localparam int          TC_W         = 20;
  localparam int          ADDR_W       = 31;
  localparam int          DATA_W       = 32;
  localparam int          FIFO_DEPTH   = 16;
  localparam logic [2:0]  BURST_BEATS  = 3'h4;
  localparam logic [2:0]  UNIT_BEATS   = 3'h1;
  localparam logic [1:0]  ACK_DROP_CYC = 2'h2;

  // ==========================================================================
  // channel control word field positions
  localparam int CTL_TC_LSB   = 0;
  localparam int CTL_SRC_LSB  = 24;
  localparam int CTL_SIZE_LSB = 20;
  localparam int CTL_BURST    = 28;
  localparam int CTL_IRQ_EN   = 29;
  localparam int CTL_WHOLE    = 27;
  localparam int CTL_HWSEL    = 23;
  localparam int CTL_HSHAKE   = 31;
  localparam logic [31:0] CTL_RESET = 32'h0000_0000;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {
    ST_WAIT = 2'b00,
    ST_LOAD = 2'b01,
    ST_RUN  = 2'b10,
    ST_DROP = 2'b11
  } main_state_t;

  typedef enum logic [1:0] {
    SUB_IDLE  = 2'b00,
    SUB_READ  = 2'b01,
    SUB_WRITE = 2'b10,
    SUB_DONE  = 2'b11
  } sub_state_t;

  typedef struct packed {
    logic              to_periph;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [1:0]        size;
  } bus_cmd_t;

  typedef struct packed {
    logic [ADDR_W-1:0] src_addr;
    logic [ADDR_W-1:0] dst_addr;
    logic              src_periph;
    logic              dst_periph;
    logic              src_fixed;
    logic              dst_fixed;
  } ch_addr_t;

endpackage

/* hdl/dma_fifo.sv */
// module: flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module dma_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0]   cnt;
  } fifo_state_t;

  fifo_state_t            s_q, s_d;
  logic [WIDTH-1:0]       mem_q [DEPTH];
  logic                   push;
  logic                   pop;

  assign in_ready  = (s_q.cnt != (AW+1)'(DEPTH));
  assign out_valid = (s_q.cnt != '0);
  assign out_data  = mem_q[s_q.rd];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb
  begin
    s_d = s_q;
    if (push)
      s_d.wr = s_q.wr + AW'(1);
    if (pop)
      s_d.rd = s_q.rd + AW'(1);
    if (push && !pop)
      s_d.cnt = s_q.cnt + (AW+1)'(1);
    else if (pop && !push)
      s_d.cnt = s_q.cnt - (AW+1)'(1);
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      s_q <= '0;
    else
      s_q <= s_d;
    if (push)
      mem_q[s_q.wr] <= in_data;
  end
endmodule // dma_fifo

/* hdl/dma_engine.sv */
// module: four-channel transfer engine with request FSM per channel and shared bus master
`timescale 1ns/1ps
module dma_engine (
  input  wire logic                                 clk,
  input  wire logic                                 rstn,
  input  wire logic [dma_pkg::NUM_CH-1:0][31:0]     channel_control_reg,
  input  wire dma_pkg::ch_addr_t [dma_pkg::NUM_CH-1:0] ch_addr,
  input  wire logic [dma_pkg::NUM_CH-1:0]           sw_request,
  input  wire logic [dma_pkg::NUM_CH-1:0][dma_pkg::NUM_SRC-1:0] periph_request,
  input  wire logic                                 audio_tx_request,
  input  wire logic                                 audio_rx_request,
  input  wire logic                                 ext_req_pin_zero,
  input  wire logic                                 ext_req_pin_one,
  output logic [1:0]                                ext_ack_pin_n,
  output logic [dma_pkg::NUM_CH-1:0]                dma_ack,
  output logic [dma_pkg::NUM_CH-1:0]                irq_req,
  output logic [dma_pkg::NUM_CH-1:0][dma_pkg::TC_W-1:0] current_transfer_count,
  output logic                                      bus_req,
  input  wire logic                                 bus_grant,
  output logic                                      bus_lock,
  output logic                                      cmd_valid,
  output dma_pkg::bus_cmd_t                         cmd,
  output logic [dma_pkg::DATA_W-1:0]                cmd_wdata,
  input  wire logic                                 cmd_ready,
  input  wire logic                                 rd_valid,
  input  wire logic [dma_pkg::DATA_W-1:0]           rd_data
);
  localparam int NC = dma_pkg::NUM_CH;
  localparam int TW = dma_pkg::TC_W;
  localparam int AW = dma_pkg::ADDR_W;

  typedef struct packed {
    dma_pkg::main_state_t [NC-1:0] st;
    logic [NC-1:0][TW-1:0]         tc;
    logic [NC-1:0]                 ack;
    logic [NC-1:0]                 irq;
    logic [NC-1:0][1:0]            drop_cnt;
    logic [NC-1:0][AW-1:0]         src;
    logic [NC-1:0][AW-1:0]         dst;
    logic [1:0]                    sync0;
    logic [1:0]                    sync1;
    dma_pkg::sub_state_t           sub;
    logic [1:0]                    owner;
    logic [2:0]                    beats;
    logic [2:0]                    rd_cnt;
    logic [2:0]                    wr_cnt;
    logic [2:0]                    req_cnt;
    logic                          op_done;
    logic [NC-1:0]                 busy;
  } eng_state_t;

  eng_state_t                  s_q, s_d;
  logic [NC-1:0]               hw_req;
  logic [NC-1:0]               req;
  logic [NC-1:0][4:0]          src_list;
  logic                        f_in_valid;
  logic                        f_in_ready;
  logic                        f_out_valid;
  logic                        f_out_ready;
  logic [dma_pkg::DATA_W-1:0]  f_out_data;

  // size code 0/1/2 gives byte/half/word address step
  function automatic logic [AW-1:0] step(input logic [1:0] sz);
    step = AW'(1) << sz;
  endfunction

  function automatic logic [2:0] chunk_beats(input logic [31:0] ctl);
    chunk_beats = ctl[dma_pkg::CTL_BURST] ? dma_pkg::BURST_BEATS : dma_pkg::UNIT_BEATS;
  endfunction

  // the pin is only the live source when hardware select picks slot 0
  function automatic logic ext_sel(input logic [31:0] ctl);
    ext_sel = ctl[dma_pkg::CTL_HWSEL] && (ctl[dma_pkg::CTL_SRC_LSB +: 3] == 3'h0);
  endfunction

  // ==========================================================================
  // request source selection
  always_comb
  begin
    // external pins are active low, seen only after the two-stage synchroniser
    src_list[0] = {periph_request[0][4:1], ~s_q.sync1[0]};
    src_list[1] = {periph_request[1][4:3], audio_rx_request, periph_request[1][1],
                   ~s_q.sync1[1]};
    src_list[2] = {periph_request[2][4:2], audio_rx_request, audio_tx_request};
    src_list[3] = periph_request[3];
    for (int c = 0; c < NC; c++)
    begin
      hw_req[c] = src_list[c][channel_control_reg[c][dma_pkg::CTL_SRC_LSB +: 3] % 3'h5];
      req[c]    = channel_control_reg[c][dma_pkg::CTL_HWSEL] ? hw_req[c] : sw_request[c];
    end
  end

  // ==========================================================================
  // read data staging buffer between read and write phases
  assign f_in_valid  = rd_valid && (s_q.sub == dma_pkg::SUB_READ);
  assign f_out_ready = cmd_valid && cmd_ready && (s_q.sub == dma_pkg::SUB_WRITE);

  dma_fifo #(
    .WIDTH (dma_pkg::DATA_W),
    .DEPTH (dma_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rstn      (rstn),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (rd_data),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data)
  );

  // ==========================================================================
  // next state
  always_comb
  begin
    logic [31:0] ctl;
    logic        whole;
    logic        hshake;
    logic        ext;
    logic [1:0]  o;
    ctl    = '0;
    whole  = 1'b0;
    hshake = 1'b0;
    ext    = 1'b0;
    o      = s_q.owner;
    s_d    = s_q;
    s_d.sync0   = {ext_req_pin_one, ext_req_pin_zero};
    s_d.sync1   = s_q.sync0;
    s_d.op_done = 1'b0;

    // shared sub-FSM: one chunk for the owning channel, bus held throughout
    case (s_q.sub)
      dma_pkg::SUB_IDLE:
      begin
        for (int c = NC-1; c >= 0; c--)
          if (s_q.busy[c])
            o = 2'(c);
        if (s_q.busy != '0 && bus_grant)
        begin
          s_d.owner   = o;
          s_d.beats   = chunk_beats(channel_control_reg[o]);
          s_d.rd_cnt  = '0;
          s_d.wr_cnt  = '0;
          s_d.req_cnt = '0;
          s_d.sub     = dma_pkg::SUB_READ;
        end
      end
      dma_pkg::SUB_READ:
      begin
        if (cmd_valid && cmd_ready)
          s_d.req_cnt = s_q.req_cnt + 3'h1;
        if (f_in_valid && f_in_ready)
          s_d.rd_cnt = s_q.rd_cnt + 3'h1;
        if (f_in_valid && f_in_ready && s_q.rd_cnt + 3'h1 == s_q.beats)
          s_d.sub = dma_pkg::SUB_WRITE;
      end
      dma_pkg::SUB_WRITE:
      begin
        if (f_out_ready)
          s_d.wr_cnt = s_q.wr_cnt + 3'h1;
        if (f_out_ready && s_q.wr_cnt + 3'h1 == s_q.beats)
          s_d.sub = dma_pkg::SUB_DONE;
      end
      dma_pkg::SUB_DONE:
      begin
        s_d.op_done = 1'b1;
        s_d.busy[s_q.owner] = 1'b0;
        s_d.sub = dma_pkg::SUB_IDLE;
      end
      default: s_d.sub = dma_pkg::SUB_IDLE;
    endcase

    for (int c = NC-1; c >= 0; c--)
    begin
      ctl    = channel_control_reg[c];
      whole  = ctl[dma_pkg::CTL_WHOLE];
      hshake = ctl[dma_pkg::CTL_HSHAKE];
      ext    = (c < 2) && ext_sel(ctl);
      case (s_q.st[c])
        dma_pkg::ST_WAIT:
        begin
          s_d.ack[c] = 1'b0;
          if (req[c])
            s_d.st[c] = dma_pkg::ST_LOAD;
        end
        dma_pkg::ST_LOAD:
        begin
          s_d.ack[c] = 1'b1;
          s_d.irq[c] = 1'b0;
          s_d.tc[c]  = ctl[dma_pkg::CTL_TC_LSB +: TW];
          s_d.src[c] = ch_addr[c].src_addr;
          s_d.dst[c] = ch_addr[c].dst_addr;
          s_d.busy[c] = 1'b1;
          s_d.st[c]  = dma_pkg::ST_RUN;
        end
        dma_pkg::ST_RUN:
        begin
          if (s_q.op_done && s_q.owner == 2'(c))
          begin
            s_d.tc[c] = s_q.tc[c] - TW'(1);
            if (!ch_addr[c].src_fixed)
              s_d.src[c] = s_q.src[c] + AW'(s_q.beats) * step(ctl[dma_pkg::CTL_SIZE_LSB +: 2]);
            if (!ch_addr[c].dst_fixed)
              s_d.dst[c] = s_q.dst[c] + AW'(s_q.beats) * step(ctl[dma_pkg::CTL_SIZE_LSB +: 2]);
            if (s_q.tc[c] == TW'(1) && ctl[dma_pkg::CTL_IRQ_EN])
              s_d.irq[c] = 1'b1;
            // in demand mode the external request is sampled at every chunk end; whole and handshake service do not sample it
            if (whole && s_q.tc[c] != TW'(1))
              s_d.busy[c] = 1'b1;
            else if (ext && hshake && !whole)
            begin
              s_d.st[c] = dma_pkg::ST_DROP;
              s_d.drop_cnt[c] = '0;
            end
            // demand continuation stops at terminal count so the counter never wraps
            else if (ext && !whole && hw_req[c] && s_q.tc[c] != TW'(1))
            begin
              s_d.tc[c]   = s_q.tc[c] - TW'(1);
              s_d.busy[c] = 1'b1;
            end
            else
            begin
              s_d.ack[c] = 1'b0;
              s_d.st[c]  = dma_pkg::ST_WAIT;
            end
          end
        end
        dma_pkg::ST_DROP:
        begin
          // acknowledge held until the requester lets go of its pin
          if (!hw_req[c])
          begin
            s_d.ack[c] = 1'b0;
            s_d.st[c]  = dma_pkg::ST_WAIT;
          end
        end
        default: s_d.st[c] = dma_pkg::ST_WAIT;
      endcase
    end
  end

  // ==========================================================================
  // registers
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      s_q       <= '0;
      s_q.sync0 <= 2'h3;
      s_q.sync1 <= 2'h3;
    end
    else
      s_q <= s_d;
  end

  // ==========================================================================
  // outputs
  always_comb
  begin
    logic [1:0] sz;
    sz        = channel_control_reg[s_q.owner][dma_pkg::CTL_SIZE_LSB +: 2];
    cmd       = '0;
    cmd_valid = 1'b0;
    cmd_wdata = f_out_data;
    if (s_q.sub == dma_pkg::SUB_READ)
    begin
      cmd_valid     = (s_q.req_cnt != s_q.beats) && f_in_ready;
      cmd.write     = 1'b0;
      cmd.to_periph = ch_addr[s_q.owner].src_periph;
      cmd.addr      = s_q.src[s_q.owner] + AW'(s_q.req_cnt) * step(sz);
      cmd.size      = sz;
    end
    else if (s_q.sub == dma_pkg::SUB_WRITE)
    begin
      cmd_valid     = f_out_valid;
      cmd.write     = 1'b1;
      cmd.to_periph = ch_addr[s_q.owner].dst_periph;
      cmd.addr      = s_q.dst[s_q.owner] + AW'(s_q.wr_cnt) * step(sz);
      cmd.size      = sz;
    end
  end

  assign bus_req  = (s_q.busy != '0);
  assign bus_lock = (s_q.sub != dma_pkg::SUB_IDLE);
  assign dma_ack  = s_q.ack;
  assign irq_req  = s_q.irq;
  assign current_transfer_count = s_q.tc;
  assign ext_ack_pin_n = ~(s_q.ack[1:0] & {ext_sel(channel_control_reg[1]),
                                           ext_sel(channel_control_reg[0])});
endmodule // dma_engine

/* test/dma_engine_assertions.sv */
// checker of port-level timing rules of the transfer engine
`timescale 1ns/1ps
module dma_engine_chk (
  input wire logic                                        clk,
  input wire logic                                        rstn,
  input wire logic [dma_pkg::NUM_CH-1:0][31:0]            channel_control_reg,
  input wire logic                                        ext_req_pin_zero,
  input wire logic [1:0]                                  ext_ack_pin_n,
  input wire logic [dma_pkg::NUM_CH-1:0]                  dma_ack,
  input wire logic [dma_pkg::NUM_CH-1:0]                  irq_req,
  input wire logic [dma_pkg::NUM_CH-1:0][dma_pkg::TC_W-1:0] current_transfer_count,
  input wire logic                                        bus_grant,
  input wire logic                                        bus_lock,
  input wire logic                                        cmd_valid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // ==========================================================================
  // sequences
  sequence s_hs_acked;
    channel_control_reg[0][31] && !channel_control_reg[0][27] && !ext_ack_pin_n[0];
  endsequence
  sequence s_req_off;
    ext_req_pin_zero [*2];
  endsequence
  // ==========================================================================
  // properties
  property p_rst;
    disable iff (1'b0) !rstn |=> dma_ack == '0 && irq_req == '0 && ext_ack_pin_n == 2'h3
      && current_transfer_count[0] == '0;
  endproperty
  property p_load;
    $rose(dma_ack[0]) |-> current_transfer_count[0] == channel_control_reg[0][19:0];
  endproperty
  property p_dec;
    $past(rstn) && $past(dma_ack[0]) && $changed(current_transfer_count[0])
      |-> current_transfer_count[0] == $past(current_transfer_count[0]) - 20'h1;
  endproperty
  property p_irq;
    $rose(irq_req[0]) |-> current_transfer_count[0] == '0 && channel_control_reg[0][29];
  endproperty
  property p_lock;
    cmd_valid |-> bus_lock && bus_grant;
  endproperty
  property p_pin;
    !ext_ack_pin_n[0] |-> dma_ack[0] && channel_control_reg[0][23] && channel_control_reg[0][26:24] == 3'h0;
  endproperty
  property p_sync;
    $fell(ext_ack_pin_n[0]) && channel_control_reg[0][26:24] == 3'h0
      |-> !$past(ext_req_pin_zero, 1) && !$past(ext_req_pin_zero, 2);
  endproperty
  property p_whole;
    dma_ack[0] && channel_control_reg[0][27] && current_transfer_count[0] > 20'h1 |=> dma_ack[0];
  endproperty
  property p_hs;
    s_hs_acked ##0 s_req_off |-> ##[0:2] ext_ack_pin_n[0];
  endproperty
  a_rst: assert property (p_rst) else $error("state not cleared by reset");
  a_load: assert property (p_load) else $error("counter not loaded at ack");
  a_dec: assert property (p_dec) else $error("counter step not one");
  a_irq: assert property (p_irq) else $error("irq without zero count");
  a_lock: assert property (p_lock) else $error("command outside owned bus");
  a_pin: assert property (p_pin) else $error("pin ack outside ack period");
  a_sync: assert property (p_sync) else $error("pin ack too early");
  a_whole: assert property (p_whole) else $error("whole ack dropped early");
  a_hs: assert property (p_hs) else $error("handshake ack not released");
endmodule // dma_engine_chk
bind dma_engine dma_engine_chk chk_u (.clk, .rstn, .channel_control_reg, .ext_req_pin_zero,
  .ext_ack_pin_n, .dma_ack, .irq_req, .current_transfer_count, .bus_grant, .bus_lock, .cmd_valid);

/* test/bus_slave_model.sv */
// bus slave model: grants the bus, takes commands, returns read data
`timescale 1ns/1ps
module bus_slave_model (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              slow,
  input  wire logic              bus_req,
  input  wire logic              bus_lock,
  output logic                   bus_grant,
  input  wire logic              cmd_valid,
  input  wire dma_pkg::bus_cmd_t cmd,
  input  wire logic [31:0]       cmd_wdata,
  output logic                   cmd_ready,
  output logic                   rd_valid,
  output logic [31:0]            rd_data,
  output int                     n_rd,
  output int                     n_wr,
  output logic [31:0]            last_wdata,
  output logic [31:0]            last_wcmd
);
  logic [31:0] pend[$];
  logic        tick;
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      n_rd <= 0;
      n_wr <= 0;
      tick <= 1'b0;
      bus_grant <= 1'b0;
      cmd_ready <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= 32'h0;
      pend.delete();
    end
    else
    begin
      tick <= !tick;
      bus_grant <= bus_req | bus_lock;
      // slow mode stalls every other cycle on both command and data
      cmd_ready <= !slow | tick;
      if (cmd_valid && cmd_ready && cmd.write)
      begin
        n_wr <= n_wr + 1;
        last_wdata <= cmd_wdata;
        last_wcmd <= {cmd.to_periph, cmd.addr};
      end
      if (cmd_valid && cmd_ready && !cmd.write)
      begin
        n_rd <= n_rd + 1;
        pend.push_back({1'b0, cmd.addr} ^ 32'h5A5A_0000);
      end
      rd_valid <= 1'b0;
      // idle data bus toggles so a stale value never looks valid
      rd_data <= ~rd_data;
      if (pend.size() > 0 && (!slow | tick))
      begin
        rd_valid <= 1'b1;
        rd_data <= pend.pop_front();
      end
    end
  end
endmodule // bus_slave_model

/* test/tb.sv */
// self-checking testbench of the transfer engine
`timescale 1ns/1ps
module tb;
  logic                            clk;
  logic                            rstn;
  logic [3:0][31:0]                ctl;
  dma_pkg::ch_addr_t [3:0]         adr;
  logic [3:0]                      sw;
  logic [3:0][4:0]                 prq;
  logic                            atx;
  logic                            arx;
  logic                            pz;
  logic                            po;
  logic                            slow;
  logic [1:0]                      pin_n;
  logic [3:0]                      dma_ack;
  logic [3:0]                      irq;
  logic [3:0][19:0]                cnt;
  logic                            breq;
  logic                            gnt;
  logic                            lock;
  logic                            cvalid;
  dma_pkg::bus_cmd_t               cmd;
  logic [31:0]                     wdata;
  logic                            crdy;
  logic                            rvalid;
  logic [31:0]                     rdata;
  logic [31:0]                     lastw;
  logic [31:0]                     lastwc;
  int                              n_rd;
  int                              n_wr;
  int                              fails;
  int                              n_compared;
  int                              r0;
  int                              w0;
  dma_engine dut_u (.clk(clk), .rstn(rstn), .channel_control_reg(ctl), .ch_addr(adr),
    .sw_request(sw), .periph_request(prq), .audio_tx_request(atx), .audio_rx_request(arx),
    .ext_req_pin_zero(pz), .ext_req_pin_one(po), .ext_ack_pin_n(pin_n), .dma_ack(dma_ack),
    .irq_req(irq), .current_transfer_count(cnt), .bus_req(breq), .bus_grant(gnt),
    .bus_lock(lock), .cmd_valid(cvalid), .cmd(cmd), .cmd_wdata(wdata), .cmd_ready(crdy),
    .rd_valid(rvalid), .rd_data(rdata));
  bus_slave_model slave_u (.clk(clk), .rstn(rstn), .slow(slow), .bus_req(breq), .bus_lock(lock),
    .bus_grant(gnt), .cmd_valid(cvalid), .cmd(cmd), .cmd_wdata(wdata), .cmd_ready(crdy),
    .rd_valid(rvalid), .rd_data(rdata), .n_rd(n_rd), .n_wr(n_wr), .last_wdata(lastw), .last_wcmd(lastwc));
  // ==========================================================================
  // helpers
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wait_ack(input int c, input logic lv);
    for (int i = 0; i < 300 && dma_ack[c] !== lv; i++) @(negedge clk);
    chk("ack", 32'(lv), 32'(dma_ack[c]));
  endtask
  task automatic wait_pin(input int c, input logic lv);
    for (int i = 0; i < 300 && pin_n[c] !== lv; i++) @(negedge clk);
    chk("ack_pin", 32'(lv), 32'(pin_n[c]));
  endtask
  function automatic logic [31:0] mk(input int tc, input bit wh, bu, hw, hs, input int src);
    logic [31:0] v;
    v = 32'(tc);
    v[dma_pkg::CTL_SIZE_LSB+:2] = 2'h2;
    v[dma_pkg::CTL_WHOLE] = wh;
    v[dma_pkg::CTL_BURST] = bu;
    v[dma_pkg::CTL_HWSEL] = hw;
    v[dma_pkg::CTL_HSHAKE] = hs;
    v[dma_pkg::CTL_IRQ_EN] = 1'b1;
    v[dma_pkg::CTL_SRC_LSB+:3] = 3'(src);
    return v;
  endfunction
  task automatic mark();
    r0 = n_rd;
    w0 = n_wr;
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_reset();
    chk("ack", 32'h0, 32'(dma_ack));
    chk("irq", 32'h0, 32'(irq));
    chk("pins", 32'h3, 32'(pin_n));
    chk("cnt", 32'h0, 32'(cnt[0]));
  endtask
  task automatic t_whole();
    ctl[3] = mk(3, 1, 0, 0, 0, 0);
    mark();
    sw[3] = 1'b1;
    wait_ack(3, 1'b1);
    sw[3] = 1'b0;
    wait_ack(3, 1'b0);
    @(negedge clk);
    chk("cnt", 32'h0, 32'(cnt[3]));
    chk("irq", 32'h1, 32'(irq[3]));
    chk("writes", 32'h3, 32'(n_wr - w0));
    chk("reads", 32'h3, 32'(n_rd - r0));
    chk("wdata", {1'b0, adr[3].src_addr} ^ 32'h5A5A_0000, lastw);
    chk("waddr", {adr[3].dst_periph, adr[3].dst_addr + 31'h8}, lastwc);
  endtask
  task automatic t_burst();
    slow = 1'b1;
    for (int k = 1; k >= 0; k--)
    begin
      // every load reloads the counter, so each request carries its own count
      ctl[1] = mk(k + 1, 0, 1, 0, 0, 0);
      mark();
      sw[1] = 1'b1;
      wait_ack(1, 1'b1);
      sw[1] = 1'b0;
      wait_ack(1, 1'b0);
      @(negedge clk);
      chk("cnt", 32'(k), 32'(cnt[1]));
      chk("irq", 32'(k == 0), 32'(irq[1]));
      chk("reads", 32'h4, 32'(n_rd - r0));
      chk("writes", 32'h4, 32'(n_wr - w0));
    end
    slow = 1'b0;
  endtask
  task automatic t_select();
    ctl[2] = mk(1, 0, 0, 1, 0, 3);
    sw[2] = 1'b1;
    repeat (10) @(negedge clk);
    chk("ack", 32'h0, 32'(dma_ack[2]));
    sw[2] = 1'b0;
    prq[2][3] = 1'b1;
    wait_ack(2, 1'b1);
    prq[2][3] = 1'b0;
    wait_ack(2, 1'b0);
    ctl[2] = mk(1, 0, 0, 0, 0, 3);
    prq[2][3] = 1'b1;
    repeat (10) @(negedge clk);
    chk("ack", 32'h0, 32'(dma_ack[2]));
    prq[2][3] = 1'b0;
  endtask
  task automatic t_audio();
    ctl[2] = mk(1, 0, 0, 1, 0, 0);
    atx = 1'b1;
    wait_ack(2, 1'b1);
    atx = 1'b0;
    wait_ack(2, 1'b0);
    ctl[1] = mk(1, 0, 0, 1, 0, 2);
    arx = 1'b1;
    wait_ack(1, 1'b1);
    arx = 1'b0;
    wait_ack(1, 1'b0);
  endtask
  task automatic t_hshake(input bit wh);
    ctl[0] = mk(2, wh, 0, 1, 1, 0);
    mark();
    wait_pin(0, 1'b1);
    pz = 1'b0;
    wait_pin(0, 1'b0);
    // whole service ignores the pin once acknowledged, so the requester lets go early
    if (!wh)
    begin
      repeat (30) @(negedge clk);
      chk("ack_pin", 32'h0, 32'(pin_n[0]));
    end
    pz = 1'b1;
    wait_pin(0, 1'b1);
    chk("writes", wh ? 32'h2 : 32'h1, 32'(n_wr - w0));
    chk("cnt", wh ? 32'h0 : 32'h1, 32'(cnt[0]));
  endtask
  task automatic t_demand();
    ctl[1] = mk(3, 0, 0, 1, 0, 0);
    mark();
    po = 1'b0;
    wait_pin(1, 1'b0);
    for (int i = 0; i < 300 && cnt[1] !== 20'h1; i++) @(negedge clk);
    chk("writes", 32'h2, 32'(n_wr - w0));
    po = 1'b1;
    wait_pin(1, 1'b1);
    repeat (10) @(negedge clk);
    chk("writes", 32'h3, 32'(n_wr - w0));
    chk("cnt", 32'h0, 32'(cnt[1]));
  endtask
  task automatic stop_test();
    if (fails == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ==========================================================================
  // clock, reset, sequence and watchdog
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    rstn = 1'b0;
    ctl = '0;
    sw = '0;
    prq = '0;
    atx = 1'b0;
    arx = 1'b0;
    pz = 1'b1;
    po = 1'b1;
    slow = 1'b0;
    fails = 0;
    n_compared = 0;
    for (int c = 0; c < 4; c++)
      adr[c] = '{31'(32'h100 * (c + 1)), 31'(32'h8000 + 32'h100 * c), c[0], c[1], 1'b1, 1'b0};
    repeat (16) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    t_reset();
    t_whole();
    t_burst();
    t_select();
    t_audio();
    t_hshake(1'b0);
    t_hshake(1'b1);
    t_demand();
    stop_test();
  end
  initial
  begin
    #400000;
    fails++;
    stop_test();
  end
endmodule // tb
